/* File: hmstc_core.sv */
// machine status, trap control and interrupt delegation logic of a hart
// Operation
// - trap into machine saves virt mode
// - machine return restores virt unless previous priv 3
// - guest virtual trap value sets guest flag
// - other machine traps clear guest flag
// - wide layout: bits 39 and 38
// - narrow layout: upper word bits 7, 6
// - sret and vm traps only in HS
// - wait timeout applies outside machine mode
// - vm trap blocks HS guest stage ops
// - vs stage ops never blocked by vm trap
// - modify priv off: current mode applies
// - modify priv on: use saved mode, priv
// - saved non-virt: user or HS, single stage
// - saved priv 3: machine access, untranslated
// - saved virt: two stage, VU or VS
// - HS readable-exec both stages, VS copy limited
// - VS access uses guest user-access bit
// - hypervisor loads/stores ignore modify priv
// - VS interrupt delegation bits read one
// - guest external delegation bit one if present
// - undelegated bits zero hypervisor copies
// - status holds all supervisor status fields
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "hmstc_params.svh"

module hmstc_core import hmstc_pkg::*; #(
	parameter int MACHINE_WORD_WIDTH = 64, // machine word width, 64 or 32
	parameter int GUEST_EXT_IRQ_COUNT = 1 // number of guest external interrupts
) (
	input wire logic mclk_i, // hart clock
	input wire logic rst_i, // synchronous reset, active high
	input wire logic ce_i, // clock enable, freezes all state when low
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic trap_m_i, // pulse: trap taken into machine mode
	input wire logic trap_gva_i, // trap value is a guest virtual address
	input wire logic machine_return_i, // pulse: machine return executed
	input wire logic mode_set_i, // pulse: other mode change (sret, s trap)
	input wire logic [1:0] mode_priv_i, // privilege for mode_set_i
	input wire logic mode_virt_i, // virtualization mode for mode_set_i
	input wire logic hyp_ldst_i, // access is a virt_load/virt_exec_load/virt_store
	input wire logic hyp_prev_priv_field_i, // hypervisor saved privilege
	input wire logic vs_sum_i, // guest status user-access bit
	input wire logic vs_mxr_i, // guest status exec-readable bit
	input wire logic vs_be_i, // guest endianness for virtual levels
	input wire logic gstage_csr_i, // instruction touches guest_stage_root
	input wire logic gstage_fence_i, // guest_stage_fence or guest_stage_inval
	input wire logic vsstage_op_i, // vs_stage_root, vs_stage_fence or inval
	input wire logic [15:0] irq_pend_i, // hardware pending interrupt lines
	output logic virt_mode_o, // current virtualization mode
	output logic [1:0] priv_o, // current privilege
	output logic [1:0] eff_priv_o, // privilege of explicit accesses
	output logic eff_virt_o, // virtualization of explicit accesses
	output logic no_xlate_o, // explicit access is untranslated
	output logic two_stage_o, // explicit access uses two stages
	output logic eff_sum_o, // user-access bit for the access
	output logic hs_mxr_o, // exec-readable over both stages
	output logic vs_mxr_o, // exec-readable at vs stage only
	output logic eff_be_o, // big-endian explicit access
	output logic sret_trap_o, // sret must trap
	output logic gstage_trap_o, // guest stage op must trap
	output logic wfi_trap_o, // wait timeout is armed
	output logic [15:0] hideleg_o, // effective hypervisor delegation
	output logic [15:0] hie_o // effective hypervisor enables
);

	// ----------------------------------------------------------------------
	// state and derived views
	// ----------------------------------------------------------------------
	hmstc_st_s st; // registered state
	hmstc_st_s next_st; // next state
	logic [15:0] mideleg_eff; // delegation with forced ones
	logic [15:0] sgei_one; // guest external bit when present
	logic [63:0] mst_view; // status as software reads it
	logic in_hs; // current mode is HS
	logic wr_fire; // write performed this cycle
	logic rd_fire; // read taken this cycle
	logic [31:0] rd_word; // decoded read data
	logic rd_hit; // read address mapped
	logic wr_hit; // write address mapped
	logic [31:0] wr_word; // merged write data

	// merge strobed bytes into an old word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// guest external delegation bit exists only with guest interrupts
	assign sgei_one = (GUEST_EXT_IRQ_COUNT != 0) ? `HMS_SGEI_MASK : 16'h0000;
	// vs-level bits are always delegated
	assign mideleg_eff = st.mideleg | `HMS_MIDELEG_RO1 | sgei_one;
	assign in_hs = (st.priv == `HMS_PRIV_S) && !st.virt;

	// status view: reserved bits zero, width fields fixed, summary dirty
	always_comb begin
		mst_view = st.mst & {`HMS_MST_WMASK_HI, `HMS_MST_WMASK_LO};
		if (MACHINE_WORD_WIDTH == 64) begin
			mst_view[63:32] = mst_view[63:32] | `HMS_MST_XL64;
			mst_view[`HMS_B_SD64] = (st.mst[`HMS_B_FS_LO +: 2] == `HMS_CTX_DIRTY) ||
				(st.mst[`HMS_B_VS_LO +: 2] == `HMS_CTX_DIRTY);
		end else begin
			mst_view[`HMS_B_SD32] = (st.mst[`HMS_B_FS_LO +: 2] == `HMS_CTX_DIRTY) ||
				(st.mst[`HMS_B_VS_LO +: 2] == `HMS_CTX_DIRTY);
		end
	end

	// ----------------------------------------------------------------------
	// register read decode
	// ----------------------------------------------------------------------
	always_comb begin
		rd_word = 32'h00000000;
		rd_hit = 1'b1;
		case (s_axi_araddr)
			`HMS_OFF_MST_LO: rd_word = mst_view[31:0];
			// the upper word is the wide layout's top half or the narrow upper register
			`HMS_OFF_MST_HI: rd_word = mst_view[63:32];
			`HMS_OFF_MIDELEG: rd_word = {16'h0000, mideleg_eff};
			`HMS_OFF_HIDELEG: rd_word = {16'h0000, hideleg_o};
			`HMS_OFF_HIP: rd_word = {16'h0000, (st.hip | irq_pend_i) & `HMS_HYP_WMASK &
				mideleg_eff};
			`HMS_OFF_HIE: rd_word = {16'h0000, hie_o};
			`HMS_OFF_MODE: rd_word = {29'h00000000, st.virt, st.priv};
			default: rd_hit = 1'b0;
		endcase
	end

	// write address decode
	always_comb begin
		case (st.awaddr)
			`HMS_OFF_MST_LO, `HMS_OFF_MST_HI, `HMS_OFF_MIDELEG, `HMS_OFF_HIDELEG,
			`HMS_OFF_HIP, `HMS_OFF_HIE, `HMS_OFF_MODE: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------------
	// bus handshakes
	// ----------------------------------------------------------------------
	assign s_axi_awready = ce_i && !st.aw_got && !st.bvalid;
	assign s_axi_wready = ce_i && !st.w_got && !st.bvalid;
	assign s_axi_arready = ce_i && !st.rvalid;
	assign wr_fire = st.aw_got && st.w_got && !st.bvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign wr_word = merge(32'h00000000, st.wdata, st.wstrb);

	// ----------------------------------------------------------------------
	// next state: bus write, then mode changes, then traps
	// ----------------------------------------------------------------------
	always_comb begin
		next_st = st;
		// write channel capture
		if (s_axi_awvalid && s_axi_awready) begin
			next_st.aw_got = 1'b1;
			next_st.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_st.w_got = 1'b1;
			next_st.wdata = s_axi_wdata;
			next_st.wstrb = s_axi_wstrb;
		end
		// write execution once both halves are held
		if (wr_fire) begin
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = wr_hit ? `HMS_RESP_OKAY : `HMS_RESP_SLVERR;
			case (st.awaddr)
				`HMS_OFF_MST_LO: begin
					next_st.mst[31:0] = (merge(st.mst[31:0], st.wdata, st.wstrb) &
						`HMS_MST_WMASK_LO) | (st.mst[31:0] & ~`HMS_MST_WMASK_LO);
					// reserved privilege code keeps the old field
					if (next_st.mst[`HMS_B_MPP_HI:`HMS_B_MPP_LO] == `HMS_PRIV_BAD) begin
						next_st.mst[`HMS_B_MPP_HI:`HMS_B_MPP_LO] =
							st.mst[`HMS_B_MPP_HI:`HMS_B_MPP_LO];
					end
				end
				`HMS_OFF_MST_HI: begin
					next_st.mst[63:32] = (merge(st.mst[63:32], st.wdata, st.wstrb) &
						`HMS_MST_WMASK_HI) | (st.mst[63:32] & ~`HMS_MST_WMASK_HI);
				end
				`HMS_OFF_MIDELEG: begin
					next_st.mideleg = wr_word[15:0] & `HMS_MIDELEG_WMASK;
				end
				`HMS_OFF_HIDELEG: begin
					next_st.hideleg = 16'(merge({16'h0000, st.hideleg}, st.wdata,
						st.wstrb) & `HMS_HYP_WMASK);
				end
				`HMS_OFF_HIP: begin
					next_st.hip = 16'(merge({16'h0000, st.hip}, st.wdata, st.wstrb) &
						`HMS_HIP_WMASK);
				end
				`HMS_OFF_HIE: begin
					next_st.hie = 16'(merge({16'h0000, st.hie}, st.wdata, st.wstrb) &
						`HMS_HYP_WMASK);
				end
				default: begin
					// read-only or unmapped: nothing stored
				end
			endcase
		end
		// write response drained
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		// read channel
		if (rd_fire) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = rd_word;
			next_st.rresp = rd_hit ? `HMS_RESP_OKAY : `HMS_RESP_SLVERR;
		end else if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		// mode change from sret or a supervisor trap
		if (mode_set_i) begin
			next_st.priv = mode_priv_i;
			next_st.virt = mode_virt_i;
		end
		// machine return restores the saved mode
		if (machine_return_i) begin
			next_st.priv = st.mst[`HMS_B_MPP_HI:`HMS_B_MPP_LO];
			next_st.virt = (st.mst[`HMS_B_MPP_HI:`HMS_B_MPP_LO] == `HMS_PRIV_M) ? 1'b0 :
				st.mst[`HMS_B_MPV];
			next_st.mst[`HMS_B_MIE] = st.mst[`HMS_B_MPIE];
			next_st.mst[`HMS_B_MPIE] = 1'b1;
			next_st.mst[`HMS_B_MPP_HI:`HMS_B_MPP_LO] = `HMS_PRIV_U;
			next_st.mst[`HMS_B_MPV] = 1'b0;
			if (st.mst[`HMS_B_MPP_HI:`HMS_B_MPP_LO] != `HMS_PRIV_M) begin
				next_st.mst[`HMS_B_MODIFY_PRIV_ENABLE] = 1'b0;
			end
		end
		// trap into machine mode wins over everything else this cycle
		if (trap_m_i) begin
			next_st.mst[`HMS_B_MPV] = st.virt;
			next_st.mst[`HMS_B_GVA] = trap_gva_i;
			next_st.mst[`HMS_B_MPP_HI:`HMS_B_MPP_LO] = st.priv;
			next_st.mst[`HMS_B_MPIE] = st.mst[`HMS_B_MIE];
			next_st.mst[`HMS_B_MIE] = 1'b0;
			next_st.priv = `HMS_PRIV_M;
			next_st.virt = 1'b0;
		end
	end

	// state register with reset and clock enable
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st <= '0;
			st.mst <= `HMS_MST_RESET;
			st.priv <= `HMS_PRIV_M;
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------------
	// explicit access mode selection
	// ----------------------------------------------------------------------
	always_comb begin
		if (hyp_ldst_i) begin
			// hypervisor loads and stores act as virtual at the saved level
			eff_virt_o = 1'b1;
			eff_priv_o = {1'b0, hyp_prev_priv_field_i};
			no_xlate_o = 1'b0;
		end else if (st.mst[`HMS_B_MODIFY_PRIV_ENABLE]) begin
			if (st.mst[`HMS_B_MPP_HI:`HMS_B_MPP_LO] == `HMS_PRIV_M) begin
				eff_virt_o = 1'b0;
				eff_priv_o = `HMS_PRIV_M;
				no_xlate_o = 1'b1;
			end else begin
				eff_virt_o = st.mst[`HMS_B_MPV];
				eff_priv_o = st.mst[`HMS_B_MPP_HI:`HMS_B_MPP_LO];
				no_xlate_o = 1'b0;
			end
		end else begin
			eff_virt_o = st.virt;
			eff_priv_o = st.priv;
			no_xlate_o = (st.priv == `HMS_PRIV_M);
		end
	end

	// second stage only for virtual accesses
	assign two_stage_o = eff_virt_o && !no_xlate_o;
	// the guest's user-access bit replaces the host's at VS level
	assign eff_sum_o = (eff_virt_o && eff_priv_o == `HMS_PRIV_S) ? vs_sum_i :
		st.mst[`HMS_B_SUM];
	// host exec-readable spans both stages, guest copy only its own stage
	assign hs_mxr_o = st.mst[`HMS_B_MXR];
	assign vs_mxr_o = two_stage_o && vs_mxr_i;
	// endianness follows the effective level
	assign eff_be_o = (eff_priv_o == `HMS_PRIV_M) ? st.mst[`HMS_B_MBE] :
		eff_virt_o ? vs_be_i :
		(eff_priv_o == `HMS_PRIV_S) ? st.mst[`HMS_B_SBE] : st.mst[`HMS_B_UBE];

	// ----------------------------------------------------------------------
	// trap controls and delegation outputs
	// ----------------------------------------------------------------------
	assign sret_trap_o = st.mst[`HMS_B_TSR] && in_hs;
	// vs-stage operations are not part of this term
	assign gstage_trap_o = st.mst[`HMS_B_TVM] && in_hs &&
		(gstage_csr_i || gstage_fence_i);
	assign wfi_trap_o = st.mst[`HMS_B_TW] && (st.priv != `HMS_PRIV_M);
	assign hideleg_o = st.hideleg & mideleg_eff;
	assign hie_o = st.hie & mideleg_eff;
	assign virt_mode_o = st.virt;
	assign priv_o = st.priv;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;

	// ----------------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	sequence trap_seq;
		ce_i && trap_m_i;
	endsequence

	sequence machine_return_seq;
		ce_i && machine_return_i && !trap_m_i;
	endsequence

	trap_saves_virt_a: assert property (trap_seq |=> st.mst[`HMS_B_MPV] == $past(st.virt)
		&& st.priv == `HMS_PRIV_M && !st.virt) else $error("trap did not save virt");
	machine_return_restore_a: assert property (machine_return_seq ##0
		(st.mst[`HMS_B_MPP_HI:`HMS_B_MPP_LO] != `HMS_PRIV_M) |=>
		st.virt == $past(st.mst[`HMS_B_MPV])) else $error("return lost virt");
	machine_return_mlevel_a: assert property (machine_return_seq ##0
		(st.mst[`HMS_B_MPP_HI:`HMS_B_MPP_LO] == `HMS_PRIV_M) |=> !st.virt)
		else $error("return to machine set virt");
	gva_follows_a: assert property (trap_seq |=> st.mst[`HMS_B_GVA] == $past(trap_gva_i))
		else $error("guest flag wrong after trap");
	hi_word_read_a: assert property (rd_fire && s_axi_araddr == `HMS_OFF_MST_HI &&
		!trap_m_i && !machine_return_i && !wr_fire |=> s_axi_rvalid &&
		s_axi_rdata[`HMS_HI_MPV] == st.mst[`HMS_B_MPV] &&
		s_axi_rdata[`HMS_HI_GVA] == st.mst[`HMS_B_GVA]) else $error("upper word bits wrong");
	sret_hs_only_a: assert property (sret_trap_o |-> !st.virt && st.priv == `HMS_PRIV_S)
		else $error("sret trap outside HS");
	wfi_mode_a: assert property (st.mst[`HMS_B_TW] && st.priv != `HMS_PRIV_M |-> wfi_trap_o)
		else $error("wait timeout not armed");
	gstage_block_a: assert property (st.mst[`HMS_B_TVM] && in_hs && gstage_fence_i |->
		gstage_trap_o) else $error("guest fence not refused");
	vsstage_free_a: assert property (vsstage_op_i && !gstage_csr_i && !gstage_fence_i |->
		!gstage_trap_o) else $error("vs stage op refused");
	mlevel_access_a: assert property (!hyp_ldst_i && st.mst[`HMS_B_MODIFY_PRIV_ENABLE] &&
		st.mst[`HMS_B_MPP_HI:`HMS_B_MPP_LO] == `HMS_PRIV_M |-> no_xlate_o &&
		eff_priv_o == `HMS_PRIV_M && !two_stage_o) else $error("machine access translated");
	hyp_access_a: assert property (hyp_ldst_i |-> two_stage_o &&
		eff_priv_o == {1'b0, hyp_prev_priv_field_i}) else $error("hyp access mode wrong");
	deleg_read_a: assert property (rd_fire && s_axi_araddr == `HMS_OFF_MIDELEG |=>
		(s_axi_rdata[15:0] & `HMS_MIDELEG_RO1) == `HMS_MIDELEG_RO1)
		else $error("vs delegation bits not one");
	hyp_masked_a: assert property ((hideleg_o & ~mideleg_eff) == 16'h0000 &&
		(hie_o & ~mideleg_eff) == 16'h0000) else $error("undelegated bit visible");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");

endmodule
`default_nettype wire

/* File: hmstc_params.svh */
// constant names for the machine status, trap control and delegation block
`ifndef HMSTC_PARAMS_SVH
`define HMSTC_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte offsets on the axi4-lite bus
// ----------------------------------------------------------------------
`define HMS_OFF_MST_LO 8'h00
`define HMS_OFF_MST_HI 8'h04
`define HMS_OFF_MIDELEG 8'h08
`define HMS_OFF_HIDELEG 8'h0c
`define HMS_OFF_HIP 8'h10
`define HMS_OFF_HIE 8'h14
`define HMS_OFF_MODE 8'h18

// ----------------------------------------------------------------------
// field positions of the 64-bit machine status image
// ----------------------------------------------------------------------
`define HMS_B_SIE 1
`define HMS_B_MIE 3
`define HMS_B_UBE 6
`define HMS_B_MPIE 7
`define HMS_B_VS_LO 9
`define HMS_B_MPP_LO 11
`define HMS_B_MPP_HI 12
`define HMS_B_FS_LO 13
`define HMS_B_MODIFY_PRIV_ENABLE 17
`define HMS_B_SUM 18
`define HMS_B_MXR 19
`define HMS_B_TVM 20
`define HMS_B_TW 21
`define HMS_B_TSR 22
`define HMS_B_SD32 31
`define HMS_B_SBE 36
`define HMS_B_MBE 37
`define HMS_B_GVA 38
`define HMS_B_MPV 39
`define HMS_B_SD64 63
`define HMS_HI_GVA 6
`define HMS_HI_MPV 7
`define HMS_MST_WMASK_LO 32'h007e7fea
`define HMS_MST_WMASK_HI 32'h000000f0
`define HMS_MST_XL64 32'h0000000a
`define HMS_MST_RESET 64'h0000000000000000
`define HMS_CTX_DIRTY 2'b11

// ----------------------------------------------------------------------
// interrupt delegation masks, privilege codes, bus answers
// ----------------------------------------------------------------------
`define HMS_IRQ_W 16
`define HMS_MIDELEG_WMASK 16'h2222
`define HMS_MIDELEG_RO1 16'h0444
`define HMS_SGEI_MASK 16'h1000
`define HMS_HYP_WMASK 16'h1444
`define HMS_HIP_WMASK 16'h0004
`define HMS_PRIV_U 2'b00
`define HMS_PRIV_S 2'b01
`define HMS_PRIV_M 2'b11
`define HMS_PRIV_BAD 2'b10
`define HMS_RESP_OKAY 2'b00
`define HMS_RESP_SLVERR 2'b10

`endif

/* File: hmstc_pkg.sv */
// types shared by the machine status, trap control and delegation block
package hmstc_pkg;
	// whole register and bus state of the block
	typedef struct packed {
		logic [63:0] mst; // machine status image
		logic [15:0] mideleg; // stored delegation bits
		logic [15:0] hideleg; // stored hypervisor delegation
		logic [15:0] hip; // stored hypervisor pending
		logic [15:0] hie; // stored hypervisor enable
		logic virt; // current virtualization mode
		logic [1:0] priv; // current privilege
		logic aw_got; // write address held
		logic [7:0] awaddr; // held write address
		logic w_got; // write data held
		logic [31:0] wdata; // held write data
		logic [3:0] wstrb; // held byte strobes
		logic bvalid; // write answer pending
		logic [1:0] bresp; // write answer code
		logic rvalid; // read answer pending
		logic [31:0] rdata; // read answer data
		logic [1:0] rresp; // read answer code
	} hmstc_st_s;
endpackage

/* File: tb.sv */
// self-checking bench for the machine status, trap control and delegation block
`timescale 1ns/1ps
`default_nettype none
`include "hmstc_params.svh"
module tb import hmstc_pkg::*;;
	logic mclk_i, rst_i, ce_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, mode_priv_i, priv_o, eff_priv_o;
	logic trap_m_i, trap_gva_i, machine_return_i, mode_set_i, mode_virt_i, hyp_ldst_i, hyp_prev_priv_field_i;
	logic vs_sum_i, vs_mxr_i, vs_be_i, gstage_csr_i, gstage_fence_i, vsstage_op_i;
	logic virt_mode_o, eff_virt_o, no_xlate_o, two_stage_o, eff_sum_o, hs_mxr_o, vs_mxr_o;
	logic eff_be_o, sret_trap_o, gstage_trap_o, wfi_trap_o;
	logic [15:0] irq_pend_i, hideleg_o, hie_o;
	logic [31:0] rv, seed, d, e;
	int fail_count, comparisons;
	// device under test, all ports by name
	hmstc_core #(.MACHINE_WORD_WIDTH(64), .GUEST_EXT_IRQ_COUNT(1)) uut (.*);
	// ----------------------------------------------------------------------
	// clock, watchdog, helpers
	// ----------------------------------------------------------------------
	initial begin
		mclk_i = 0;
		forever #25 mclk_i = ~mclk_i;
	end
	// the tests need well under two hundred cycles; far beyond means a hang
	initial begin
		repeat (20000) @(posedge mclk_i);
		fail_count++;
		end_of_test();
	end
	// xorshift source, seeded at 17
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] g);
		comparisons++;
		if (g !== ex) begin
			fail_count++;
			$display("BAD %s exp %h got %h", n, ex, g);
		end
	endtask
	// one write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ad, wd, ra, wa;
		ad = 0;
		wd = 0;
		@(posedge mclk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		// readies are sampled settled, before the edge that takes them
		while (!(ad && wd)) begin
			@(negedge mclk_i);
			ra = s_axi_awready;
			wa = s_axi_wready;
			@(posedge mclk_i);
			if (!ad && ra === 1'b1) begin
				ad = 1;
				s_axi_awvalid <= 0;
			end
			if (!wd && wa === 1'b1) begin
				wd = 1;
				s_axi_wvalid <= 0;
			end
		end
		s_axi_bready <= 1;
		do begin
			@(negedge mclk_i);
			ra = s_axi_bvalid;
			@(posedge mclk_i);
		end while (ra !== 1'b1);
		s_axi_bready <= 0;
	endtask
	task automatic rd(input logic [7:0] a);
		logic ok;
		@(posedge mclk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do begin
			@(negedge mclk_i);
			ok = s_axi_arready;
			@(posedge mclk_i);
		end while (ok !== 1'b1);
		s_axi_arvalid <= 0;
		s_axi_rready <= 1;
		do begin
			@(negedge mclk_i);
			ok = s_axi_rvalid;
			rv = s_axi_rdata;
			@(posedge mclk_i);
		end while (ok !== 1'b1);
		s_axi_rready <= 0;
	endtask
	// one-cycle event pulse, then settle to mid-cycle
	task automatic pulse(input int k);
		@(posedge mclk_i);
		trap_m_i <= (k == 0);
		machine_return_i <= (k == 1);
		mode_set_i <= (k == 2);
		@(posedge mclk_i);
		{trap_m_i, machine_return_i, mode_set_i} <= 3'b000;
		@(negedge mclk_i);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// ----------------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------------
	initial begin
		seed = 32'd17;
		{rst_i, ce_i} = 2'b11;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hf};
		{trap_m_i, trap_gva_i, machine_return_i, mode_set_i, mode_priv_i, mode_virt_i} = 0;
		{hyp_ldst_i, hyp_prev_priv_field_i, vs_sum_i, vs_mxr_i, vs_be_i} = 0;
		{gstage_csr_i, gstage_fence_i, vsstage_op_i, irq_pend_i} = 0;
		repeat (2) @(posedge mclk_i);
		rst_i <= 0;
		rd(`HMS_OFF_MIDELEG);
		chk("mideleg reset", 32'h1444, rv);
		d = xs();
		wr(`HMS_OFF_MIDELEG, d);
		rd(`HMS_OFF_MIDELEG);
		chk("mideleg ro", {16'h0, d[15:0] & `HMS_MIDELEG_WMASK | 16'h1444}, rv);
		wr(`HMS_OFF_HIDELEG, 32'hffff);
		wr(`HMS_OFF_HIE, xs() | 32'h1000);
		chk("hideleg", 32'h1444, {16'h0, hideleg_o});
		chk("hie sgei", 32'h1000, {16'h0, hie_o & 16'h1000});
		rd(8'h40);
		chk("unmapped", `HMS_RESP_SLVERR, {30'h0, s_axi_rresp});
		$display("delegation test done");
		// trap from VS twice, guest flag from a fresh random bit each time
		for (int i = 0; i < 2; i++) begin
			d = xs();
			{mode_priv_i, mode_virt_i, trap_gva_i} <= {`HMS_PRIV_S, 1'b1, d[0] ^ i[0]};
			pulse(2);
			pulse(0);
			rd(`HMS_OFF_MST_HI);
			chk("status hi", 32'h8a | (trap_gva_i << 6), rv);
			rd(`HMS_OFF_MST_LO);
			chk("saved priv", `HMS_PRIV_S, {30'h0, rv[12:11]});
			pulse(1);
			chk("machine_return mode", 32'h5, {29'h0, virt_mode_o, priv_o});
		end
		pulse(0);
		wr(`HMS_OFF_MST_LO, 32'h1800);
		wr(`HMS_OFF_MST_HI, 32'h80);
		rd(`HMS_OFF_MST_HI);
		chk("sw mpv", 32'h8a, rv);
		pulse(1);
		chk("machine_return m", 32'h3, {29'h0, virt_mode_o, priv_o});
		$display("trap test done");
		// modify privilege over every saved priv and virt pair
		for (int i = 0; i < 6; i++) begin
			d = (i % 3 == 2) ? 3 : i % 3;
			wr(`HMS_OFF_MST_HI, (i / 3) << 7);
			wr(`HMS_OFF_MST_LO, 32'h20000 | (d << 11));
			@(negedge mclk_i);
			e = (d == 3) ? 32'h38 : ((d << 4) | ((i / 3) * 32'h5));
			chk("modify_priv_enable", e, {eff_priv_o, no_xlate_o, eff_virt_o, 1'b0, two_stage_o});
		end
		@(posedge mclk_i);
		{hyp_ldst_i, hyp_prev_priv_field_i, vs_sum_i, vs_mxr_i} <= 4'hf;
		@(negedge mclk_i);
		chk("hyp ldst", 32'h2f, {eff_virt_o, eff_priv_o, eff_sum_o, vs_mxr_o, two_stage_o});
		@(posedge mclk_i);
		hyp_ldst_i <= 0;
		wr(`HMS_OFF_MST_LO, 32'h780000);
		@(negedge mclk_i);
		chk("modify_priv_enable off", 32'h1e, {eff_priv_o, no_xlate_o, hs_mxr_o, eff_be_o});
		$display("modify privilege test done");
		// trap controls in HS then VS
		@(posedge mclk_i);
		{gstage_fence_i, vsstage_op_i, mode_priv_i, mode_virt_i} <= 5'b10010;
		pulse(2);
		chk("tvm hs", 32'h7, {gstage_trap_o, wfi_trap_o, sret_trap_o});
		@(posedge mclk_i);
		{gstage_fence_i, vsstage_op_i} <= 2'b01;
		@(negedge mclk_i);
		chk("tvm vs op", 32'h0, {31'h0, gstage_trap_o});
		@(posedge mclk_i);
		{gstage_csr_i, mode_virt_i} <= 2'b11;
		pulse(2);
		chk("tvm in vs", 32'h2, {gstage_trap_o, wfi_trap_o, sret_trap_o});
		$display("trap control test done");
		end_of_test();
	end
endmodule
`default_nettype wire
